/* File: pkg/spgw_pkg.sv */
// register map, field layouts, reset values and bus carriers for the six-pin gpio port
// assumes a 32-bit apb slave with one aligned word per register
package spgw_pkg;
  localparam int          NPIN          = 6;
  localparam logic [11:0] OFF_LEVEL     = 12'h000;
  localparam logic [11:0] OFF_DIR       = 12'h004;
  localparam logic [11:0] OFF_ANALOG_SELECT     = 12'h008;
  localparam logic [11:0] OFF_PULLUP    = 12'h00c;
  localparam logic [11:0] OFF_IOC       = 12'h010;
  localparam logic [11:0] OFF_CTRL      = 12'h014;
  localparam logic [11:0] OFF_STATUS    = 12'h018;
  localparam logic [5:0]  DIR_RST       = 6'h3f;
  localparam logic [7:0]  ANALOG_SELECT_RST     = 8'hff;
  localparam logic [5:0]  PULLUP_RST    = 6'h37;
  localparam logic [5:0]  IOC_RST       = 6'h00;
  localparam logic [5:0]  LATCH_RST     = 6'h00;
  localparam logic [5:0]  PULLUP_IMPL   = 6'h37;
  localparam logic [5:0]  CRYSTAL_PINS  = 6'h30;
  localparam logic [5:0]  INPUT_ONLY    = 6'h08;
  localparam int          PIN3          = 3;
  localparam int          CTRL_GPU      = 0;
  localparam int          CTRL_GIE      = 1;
  localparam int          CTRL_ULPWE    = 2;
  localparam int          STAT_FLAG     = 0;
  localparam logic [3:0]  CTRL_RST      = 4'h1;
  localparam logic [31:0] IRQ_VECTOR    = 32'h0000_0004;

  // oscillator selections seen by the port
  typedef enum logic [1:0] {
    SPGW_OSC_OTHER,
    SPGW_OSC_CRYSTAL_MEDIUM,
    SPGW_OSC_CRYSTAL_FAST,
    SPGW_OSC_CRYSTAL_LOW_POWER
  } spgw_osc_t;

  // apb request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } spgw_apb_req_t;

  // apb answer carrier
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } spgw_apb_rsp_t;
endpackage

/* File: logic/spgw_port.sv */
// six-pin gpio port with pull-ups, change detection and slow-discharge wake
// assumes apb master on CLK_IN, pins synchronised to CLK_IN inside by two flops, reset kinds decoded outside
`timescale 1ns/10ps

// Function
// - port read returns pin levels in bits 5..0, bits 7..6 zero
// - direction one tri-states the pin, zero drives the output latch
// - pin 3 direction reads one; its data bit is read-only
// - crystal modes force direction, pull-up, change enables of pins 5..4 to one
// - analog-selected pins read zero digitally
// - analog select leaves the output path untouched
// - analog select bit disables digital input, pull-up and change detect
// - pull-ups on pins 0,1,2,4,5; bit 3 reads zero
// - pull-up off while the pin is an output
// - pull-ups on pins 0,1,2,4,5 need the global pull-up control enabled
// - power-on reset leaves all pull-ups disabled via global control; pin 3 pull-up stays on while master clear is enabled
// - pin 3 pull-up follows master-clear function, no software control
// - six change enables in bits 5..0, cleared at power-on reset
// - enabled pins compared with last-read latch, mismatches ORed into change flag
// - mismatch keeps setting the flag; software reads port then clears flag
// - last-read latch survives master-clear and brown-out resets
// - set change flag wakes the device from sleep
// - a change coinciding with a port read may be missed
// - change interrupt recognised only with global interrupt enable
// - wake enable switches on a current sink on pin 0
// - pin 0 below threshold wakes; vector 0004h if interrupts enabled, else continue
// - port writes are read-modify-write into the output latch
// - pin 3 data reads zero while master-clear function is enabled
module spgw_port (
  input  wire logic                   CLK_IN,
  input  wire logic                   SRST_IN,
  input  wire logic                   POR_IN,
  input  wire spgw_pkg::spgw_apb_req_t APB_REQ_IN,
  output spgw_pkg::spgw_apb_rsp_t     APB_RSP_OUT,
  input  wire logic [5:0]             PIN_IN,
  output logic [5:0]                  PIN_OUT,
  output logic [5:0]                  PIN_OE_OUT,
  output logic [5:0]                  PULLUP_ON_OUT,
  output logic                        DISCHARGE_SINK_OUT,
  input  wire logic                   MASTER_CLEAR_FUNC_EN_IN,
  input  wire spgw_pkg::spgw_osc_t    OSC_MODE_IN,
  input  wire logic                   SLEEPING_IN,
  output logic                        WAKE_OUT,
  output logic                        IRQ_OUT,
  output logic [31:0]                 IRQ_VECTOR_OUT
);

  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] latch_r;
  logic [5:0] latch_nxt;
  logic [5:0] dir_r;
  logic [5:0] dir_nxt;
  logic [7:0] analog_select_r;
  logic [7:0] analog_select_nxt;
  logic [5:0] pullup_r;
  logic [5:0] pullup_nxt;
  logic [5:0] ioc_r;
  logic [5:0] ioc_nxt;
  logic [3:0] ctrl_r;
  logic [3:0] ctrl_nxt;
  logic [5:0] last_read_r;
  logic [5:0] last_read_nxt;
  logic       flag_r;
  logic       flag_nxt;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  // decode of the apb access phase
  wire logic access   = APB_REQ_IN.psel & APB_REQ_IN.penable;
  wire logic wr       = access & APB_REQ_IN.pwrite;
  wire logic rd       = access & ~APB_REQ_IN.pwrite;
  wire logic sel_lvl  = (APB_REQ_IN.paddr == spgw_pkg::OFF_LEVEL);
  wire logic sel_dir  = (APB_REQ_IN.paddr == spgw_pkg::OFF_DIR);
  wire logic sel_ans  = (APB_REQ_IN.paddr == spgw_pkg::OFF_ANALOG_SELECT);
  wire logic sel_pu   = (APB_REQ_IN.paddr == spgw_pkg::OFF_PULLUP);
  wire logic sel_ioc  = (APB_REQ_IN.paddr == spgw_pkg::OFF_IOC);
  wire logic sel_ctl  = (APB_REQ_IN.paddr == spgw_pkg::OFF_CTRL);
  wire logic sel_sts  = (APB_REQ_IN.paddr == spgw_pkg::OFF_STATUS);
  wire logic mapped   = sel_lvl | sel_dir | sel_ans | sel_pu | sel_ioc | sel_ctl | sel_sts;
  wire logic port_rd  = rd & sel_lvl;
  wire logic port_wr  = wr & sel_lvl;

  // crystal modes claim pins 5 and 4
  wire logic       crystal  = (OSC_MODE_IN != spgw_pkg::SPGW_OSC_OTHER);
  wire logic [5:0] xtal_msk = crystal ? spgw_pkg::CRYSTAL_PINS : 6'h00;

  // visible register values with forced bits
  wire logic [5:0] dir_vis  = dir_r | spgw_pkg::INPUT_ONLY | xtal_msk;
  wire logic [5:0] pu_vis   = (pullup_r & spgw_pkg::PULLUP_IMPL) | xtal_msk;
  wire logic [5:0] ioc_vis  = ioc_r | xtal_msk;

  // analog channels 0..2 sit on pins 0..2 and channel 3 on pin 4; pins 3 and 5 have no channel
  wire logic [5:0] pin_ana  = {1'b0, analog_select_r[3], 1'b0, analog_select_r[2:0]};
  wire logic [5:0] master_clear_msk = MASTER_CLEAR_FUNC_EN_IN ? spgw_pkg::INPUT_ONLY : 6'h00;
  wire logic       gpu_on   = ~ctrl_r[spgw_pkg::CTRL_GPU];
  wire logic [5:0] dig_in;
  wire logic [5:0] mismatch;
  wire logic [5:0] drive_en;
  wire logic [5:0] pu_sw;

  // per-pin input mask, change compare, driver enable and pull-up switch
  for (genvar i = 0; i < spgw_pkg::NPIN; i++) begin : g_pin
    // analog select and master clear force the digital read to zero
    assign dig_in[i]   = sync2_r[i] & ~pin_ana[i] & ~master_clear_msk[i];
    // enabled digital pins compare against the last-read latch
    assign mismatch[i] = (dig_in[i] ^ last_read_r[i]) & ioc_vis[i] & ~pin_ana[i];
    // analog select is not part of the output path
    assign drive_en[i] = ~dir_vis[i];
    // pull-up only where built, on an input, digital and globally enabled
    assign pu_sw[i]    = pu_vis[i] & spgw_pkg::PULLUP_IMPL[i] & dir_vis[i] & ~pin_ana[i] & gpu_on;
  end

  wire logic       any_mis  = |mismatch;

  // read multiplexer, unused bits read zero
  wire logic [31:0] rd_mux =
    sel_lvl ? {26'h0, dig_in} :
    sel_dir ? {26'h0, dir_vis} :
    sel_ans ? {24'h0, analog_select_r} :
    sel_pu  ? {26'h0, pu_vis} :
    sel_ioc ? {26'h0, ioc_vis} :
    sel_ctl ? {28'h0, ctrl_r} :
    sel_sts ? {31'h0, flag_r} : 32'h0;

  // master-clear pull-up on pin 3 follows the configuration, not software
  wire logic [5:0] pu_pin3  = MASTER_CLEAR_FUNC_EN_IN ? spgw_pkg::INPUT_ONLY : 6'h00;

  // next values of software-written registers
  always_comb begin
    latch_nxt = latch_r;
    dir_nxt   = dir_r;
    analog_select_nxt = analog_select_r;
    pullup_nxt = pullup_r;
    ioc_nxt   = ioc_r;
    ctrl_nxt  = ctrl_r;
    if (port_wr) begin
      // read-modify-write: input-only bit keeps its sampled level
      latch_nxt = (APB_REQ_IN.pwdata[5:0] & ~spgw_pkg::INPUT_ONLY) | (dig_in & spgw_pkg::INPUT_ONLY);
    end else if (wr && sel_dir) begin
      dir_nxt = APB_REQ_IN.pwdata[5:0];
    end else if (wr && sel_ans) begin
      analog_select_nxt = APB_REQ_IN.pwdata[7:0];
    end else if (wr && sel_pu) begin
      pullup_nxt = APB_REQ_IN.pwdata[5:0] & spgw_pkg::PULLUP_IMPL;
    end else if (wr && sel_ioc) begin
      ioc_nxt = APB_REQ_IN.pwdata[5:0];
    end else if (wr && sel_ctl) begin
      ctrl_nxt = APB_REQ_IN.pwdata[3:0];
    end
  end

  // last-read latch and change flag; a port read or write ends the mismatch
  always_comb begin
    last_read_nxt = last_read_r;
    flag_nxt      = flag_r;
    if (port_rd || port_wr) begin
      last_read_nxt = dig_in;
    end
    if (wr && sel_sts && APB_REQ_IN.pwdata[spgw_pkg::STAT_FLAG]) begin
      flag_nxt = 1'b0;
    end
    // a port read blocks the flag set and reloads the latch, so a change on the read edge can be lost
    if (any_mis && !port_rd) begin
      flag_nxt = 1'b1;
    end
  end

  // two-stage input synchroniser
  always_ff @(posedge CLK_IN) begin
    sync1_r <= PIN_IN;
    sync2_r <= sync1_r;
  end

  // output latch, cleared by any synchronous reset
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      latch_r <= spgw_pkg::LATCH_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // direction register, all pins inputs after reset
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      dir_r <= spgw_pkg::DIR_RST;
    end else begin
      dir_r <= dir_nxt;
    end
  end

  // analog select register, all channels analog after reset
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      analog_select_r <= spgw_pkg::ANALOG_SELECT_RST;
    end else begin
      analog_select_r <= analog_select_nxt;
    end
  end

  // per-pin pull-up enables
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      pullup_r <= spgw_pkg::PULLUP_RST;
    end else begin
      pullup_r <= pullup_nxt;
    end
  end

  // change enables, cleared by reset
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ioc_r <= spgw_pkg::IOC_RST;
    end else begin
      ioc_r <= ioc_nxt;
    end
  end

  // control word; reset leaves the global pull-up control disabling pull-ups
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ctrl_r <= spgw_pkg::CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // last-read latch: only a power-on reset clears it
  always_ff @(posedge CLK_IN) begin
    if (POR_IN) begin
      last_read_r <= spgw_pkg::LATCH_RST;
    end else begin
      last_read_r <= last_read_nxt;
    end
  end

  // change flag; after a non-power-on reset a remaining mismatch sets it again
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // setup phase of a transfer
  wire logic setup = APB_REQ_IN.psel & ~APB_REQ_IN.penable;

  // answer captured at the setup edge, so read data comes from flops in the access cycle
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= APB_REQ_IN.pwrite ? 32'h0 : rd_mux;
      pslverr_r <= ~mapped;
    end
  end

  // zero-wait-state slave: ready in every access cycle, data valid from the setup edge
  assign APB_RSP_OUT.pready  = 1'b1;
  assign APB_RSP_OUT.pslverr = access & pslverr_r;
  assign APB_RSP_OUT.prdata  = prdata_r;

  // pins, pull-ups and current sink
  assign PIN_OUT            = latch_r & drive_en;
  assign PIN_OE_OUT         = drive_en;
  assign PULLUP_ON_OUT      = pu_sw | pu_pin3;
  assign DISCHARGE_SINK_OUT = ctrl_r[spgw_pkg::CTRL_ULPWE];

  // wake and interrupt; global enable selects vector or fall-through
  assign WAKE_OUT       = flag_r & SLEEPING_IN;
  assign IRQ_OUT        = flag_r & ctrl_r[spgw_pkg::CTRL_GIE];
  assign IRQ_VECTOR_OUT = spgw_pkg::IRQ_VECTOR;

endmodule

/* File: bench/spgw_pins_model.sv */
// pin model for the six-pin port: drivers, pull-ups, floating lines, capacitor on pin 0
// assumes the bench commands external drive and the capacitor hookup
`timescale 1ns/10ps
module spgw_pins_model (
  input  wire logic       clk_in,
  input  wire logic [5:0] out_in,
  input  wire logic [5:0] oe_in,
  input  wire logic [5:0] pu_in,
  input  wire logic [5:0] ext_val_in,
  input  wire logic [5:0] ext_en_in,
  input  wire logic       sink_in,
  input  wire logic       cap_en_in,
  output logic [5:0]      lvl_out
);
  logic [5:0] last_r = 6'h00;
  logic [3:0] cap_r  = 4'h0;
  // a line remembers its last driven level; the capacitor charges from pin 0 and drains through the sink
  always @(posedge clk_in) begin
    for (int i = 0; i < 6; i++) if (oe_in[i] || ext_en_in[i] || pu_in[i]) last_r[i] <= lvl_out[i];
    if (oe_in[0] && out_in[0]) cap_r <= 4'hf;
    else if (sink_in && cap_r != 4'h0) cap_r <= cap_r - 4'h1;
  end
  // an undriven line without pull-up shows the inverse of its last driven level
  always_comb begin
    for (int i = 0; i < 6; i++) lvl_out[i] = oe_in[i] ? out_in[i] : ext_en_in[i] ? ext_val_in[i] : pu_in[i] | ~last_r[i];
    if (cap_en_in && !oe_in[0]) lvl_out[0] = cap_r[3]; // threshold at half charge
  end
endmodule

/* File: bench/spgw_port_checker.sv */
// concurrent checks on the pins and apb answers of the six-pin port
// assumes one clock domain; bound to the port at the foot of this file
`timescale 1ns/10ps
module spgw_port_checker (
  input wire logic                    CLK_IN,
  input wire logic                    SRST_IN,
  input wire spgw_pkg::spgw_apb_req_t APB_REQ_IN,
  input wire spgw_pkg::spgw_apb_rsp_t APB_RSP_OUT,
  input wire logic [5:0]              PIN_OUT,
  input wire logic [5:0]              PIN_OE_OUT,
  input wire logic [5:0]              PULLUP_ON_OUT,
  input wire logic                    DISCHARGE_SINK_OUT,
  input wire logic                    MASTER_CLEAR_FUNC_EN_IN,
  input wire logic                    SLEEPING_IN,
  input wire logic                    WAKE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  // access phase decode
  wire acc = APB_REQ_IN.psel && APB_REQ_IN.penable;
  sequence s_rd(logic [11:0] a); acc && !APB_REQ_IN.pwrite && APB_REQ_IN.paddr == a; endsequence
  sequence s_ctl_wr; acc && APB_REQ_IN.pwrite && APB_REQ_IN.paddr == spgw_pkg::OFF_CTRL; endsequence
  property p_ready; acc |-> APB_RSP_OUT.pready; endproperty
  property p_drive; (PIN_OUT & ~PIN_OE_OUT) == 6'h00; endproperty
  property p_in3; !PIN_OE_OUT[3]; endproperty
  property p_pu_out; (PULLUP_ON_OUT & PIN_OE_OUT) == 6'h00; endproperty
  property p_pu3; PULLUP_ON_OUT[3] == MASTER_CLEAR_FUNC_EN_IN; endproperty
  property p_pu_rst; $fell(SRST_IN) |-> (PULLUP_ON_OUT & spgw_pkg::PULLUP_IMPL) == 6'h00; endproperty
  property p_sink; s_ctl_wr |=> DISCHARGE_SINK_OUT == $past(APB_REQ_IN.pwdata[spgw_pkg::CTRL_ULPWE]); endproperty
  property p_wake; WAKE_OUT |-> SLEEPING_IN; endproperty
  property p_rd_hi; s_rd(spgw_pkg::OFF_LEVEL) |-> APB_RSP_OUT.prdata[31:6] == 26'h0; endproperty
  property p_dir3; s_rd(spgw_pkg::OFF_DIR) |-> APB_RSP_OUT.prdata[spgw_pkg::PIN3]; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access phase");
  a_drive: assert property (p_drive) else $error("value on undriven pin");
  a_in3: assert property (p_in3) else $error("pin 3 driven");
  a_pu_out: assert property (p_pu_out) else $error("pull-up on output pin");
  a_pu3: assert property (p_pu3) else $error("pin 3 pull-up wrong");
  a_pu_rst: assert property (p_pu_rst) else $error("pull-up on after reset");
  a_sink: assert property (p_sink) else $error("sink not per control");
  a_wake: assert property (p_wake) else $error("wake while awake");
  a_rd_hi: assert property (p_rd_hi) else $error("upper data bits set");
  a_dir3: assert property (p_dir3) else $error("pin 3 direction reads zero");
endmodule
bind spgw_port spgw_port_checker i_chk (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .APB_REQ_IN(APB_REQ_IN),
  .APB_RSP_OUT(APB_RSP_OUT), .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT), .PULLUP_ON_OUT(PULLUP_ON_OUT),
  .DISCHARGE_SINK_OUT(DISCHARGE_SINK_OUT), .MASTER_CLEAR_FUNC_EN_IN(MASTER_CLEAR_FUNC_EN_IN), .SLEEPING_IN(SLEEPING_IN),
  .WAKE_OUT(WAKE_OUT));

/* File: bench/spgw_port_tb_top.sv */
// self-checking bench for the six-pin port over apb
// assumes the pin model closes the loop from port outputs to pin inputs
`timescale 1ns/10ps
module spgw_port_tb_top;
  logic                    clk = 1'b0, srst = 1'b1, por = 1'b1, master_clear = 1'b0, slp = 1'b0, cap = 1'b0, er;
  logic [5:0]              xv = 6'h00, xe = 6'h00, po, oe, pu, lv;
  logic                    snk, wk, irq;
  logic [31:0]             vec, q;
  spgw_pkg::spgw_osc_t     osc = spgw_pkg::SPGW_OSC_OTHER;
  spgw_pkg::spgw_apb_req_t req = '0;
  spgw_pkg::spgw_apb_rsp_t rsp;
  int                      bad_count = 0, checks_done = 0, n;
  // 100 MHz clock
  always #5 clk = ~clk;
  spgw_port i_dut (.CLK_IN(clk), .SRST_IN(srst), .POR_IN(por), .APB_REQ_IN(req), .APB_RSP_OUT(rsp),
    .PIN_IN(lv), .PIN_OUT(po), .PIN_OE_OUT(oe), .PULLUP_ON_OUT(pu), .DISCHARGE_SINK_OUT(snk),
    .MASTER_CLEAR_FUNC_EN_IN(master_clear), .OSC_MODE_IN(osc), .SLEEPING_IN(slp), .WAKE_OUT(wk), .IRQ_OUT(irq),
    .IRQ_VECTOR_OUT(vec));
  spgw_pins_model i_pins (.clk_in(clk), .out_in(po), .oe_in(oe), .pu_in(pu), .ext_val_in(xv),
    .ext_en_in(xe), .sink_in(snk), .cap_en_in(cap), .lvl_out(lv));
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk) req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk) req.penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) break;
    end
    q = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    if (k == 16) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    por <= 1'b0;
    rd("dir", 12'h004, 32'h3f);
    rd("analog_select", 12'h008, 32'hff);
    rd("pullup", 12'h00c, 32'h37);
    rd("ioc", 12'h010, 32'h00);
    rd("ctrl", 12'h014, 32'h01);
    rd("unmapped", 12'h01c, 32'h0);
    chk("slverr", 32'(er), 32'h1);
    apb(1'b1, 12'h008, 32'h00);
    apb(1'b1, 12'h000, 32'h3f);
    apb(1'b1, 12'h004, 32'h00);
    xe <= 6'h08;
    xv <= 6'h08;
    repeat (3) @(posedge clk);
    chk("oe", 32'(oe), 32'h37);
    chk("out", 32'(po), 32'h37);
    rd("dir", 12'h004, 32'h08);
    rd("level", 12'h000, 32'h3f);
    master_clear <= 1'b1;
    rd("level", 12'h000, 32'h37);
    apb(1'b1, 12'h008, 32'h09);
    rd("level", 12'h000, 32'h26);
    chk("out", 32'(po), 32'h37);
    apb(1'b1, 12'h008, 32'h00);
    apb(1'b1, 12'h004, 32'h3e);
    xe <= 6'h00;
    apb(1'b1, 12'h014, 32'h00);
    @(posedge clk);
    chk("pullup_on", 32'(pu), 32'h3e);
    apb(1'b1, 12'h008, 32'h02);
    @(posedge clk);
    chk("pullup_on", 32'(pu), 32'h3c);
    apb(1'b1, 12'h004, 32'h00);
    apb(1'b1, 12'h00c, 32'h08);
    for (int m = 1; m < 4; m++) begin
      osc <= spgw_pkg::spgw_osc_t'(m);
      rd("dir", 12'h004, 32'h38);
    end
    chk("oe", 32'(oe), 32'h07);
    rd("pullup", 12'h00c, 32'h30);
    rd("ioc", 12'h010, 32'h30);
    osc <= spgw_pkg::SPGW_OSC_OTHER;
    apb(1'b1, 12'h008, 32'h00);
    apb(1'b1, 12'h014, 32'h01);
    cap <= 1'b1;
    apb(1'b1, 12'h000, 32'h01);
    apb(1'b1, 12'h010, 32'h01);
    apb(1'b1, 12'h004, 32'h01);
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b1, 12'h018, 32'h01);
    rd("flag", 12'h018, 32'h0);
    apb(1'b1, 12'h014, 32'h05);
    slp <= 1'b1;
    @(posedge clk);
    chk("sink", 32'(snk), 32'h1);
    for (n = 0; n < 64 && wk !== 1'b1; n++) @(posedge clk);
    chk("wake", 32'(wk), 32'h1);
    if (wk !== 1'b1) report_and_stop();
    chk("irq", 32'(irq), 32'h0);
    apb(1'b1, 12'h014, 32'h07);
    @(posedge clk);
    chk("irq", 32'(irq), 32'h1);
    chk("vector", vec, 32'h4);
    apb(1'b1, 12'h018, 32'h01);
    rd("flag", 12'h018, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b1, 12'h018, 32'h01);
    rd("flag", 12'h018, 32'h0);
    cap <= 1'b0;
    xe <= 6'h01;
    xv <= 6'h01;
    repeat (3) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    apb(1'b1, 12'h008, 32'h00);
    apb(1'b1, 12'h010, 32'h01);
    repeat (3) @(posedge clk);
    rd("flag", 12'h018, 32'h0);
    xv <= 6'h00;
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    apb(1'b1, 12'h008, 32'h00);
    apb(1'b1, 12'h010, 32'h01);
    repeat (3) @(posedge clk);
    rd("flag", 12'h018, 32'h1);
    report_and_stop();
  end
endmodule
